// >>> design/rtcx_pkg.sv
// Package: register map, field layout and timing constants for the RTC block
package rtcx_pkg;

  // System clock rate
  localparam int unsigned SYS_HZ        = 100_000_000;

  // Register indices (low nibble of the 5-bit pointer, mirrored twice)
  localparam logic [3:0]  IDX_PRESET_LO = 4'hB;
  localparam logic [3:0]  IDX_PRESET_HI = 4'hC;
  localparam logic [3:0]  IDX_EXT_CTRL  = 4'hD;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam logic [7:0]  UNMAPPED_BYTE = 8'h00;

  // Countdown source codes
  localparam logic [1:0]  SRC_4096HZ    = 2'h0;
  localparam logic [1:0]  SRC_64HZ      = 2'h1;
  localparam logic [1:0]  SRC_1HZ       = 2'h2;
  localparam logic [1:0]  SRC_1PER60S   = 2'h3;

  // Output clock frequency codes
  localparam logic [1:0]  OUTCLK_32K    = 2'h0;
  localparam logic [1:0]  OUTCLK_1024HZ = 2'h1;

  // Timebase: 4096 Hz base tick derived from the system clock
  localparam int unsigned BASE_HZ       = 4096;
  localparam int unsigned BASE_DIV      = SYS_HZ / BASE_HZ;
  localparam logic [5:0]  TICKS_64HZ_M1 = 6'h3F;
  localparam logic [11:0] TICKS_1HZ_M1  = 12'hFFF;
  localparam logic [5:0]  SECS_MIN_M1   = 6'h3B;

  // Update auto-return times, rounded down to whole cycles
  localparam int unsigned RTN_SEC_MS    = 500;
  localparam int unsigned RTN_MIN_US    = 15600;
  localparam int unsigned RTN_SEC_CYC   = (SYS_HZ / 1000) * RTN_SEC_MS;
  localparam int unsigned RTN_MIN_CYC   = (SYS_HZ / 1000000) * RTN_MIN_US;

  // Serial target address (arbitrary value)
  localparam logic [6:0]  DEV_ADDR_DEF  = 7'h32;

  // Extension control register layout
  typedef struct packed {
    logic       test_bit;
    logic       alarm_source_select;
    logic       update_period_select;
    logic       countdown_run;
    logic [1:0] out_clock_freq_select;
    logic [1:0] countdown_source_select;
  } rtcx_ext_t;

  // High preset register layout
  typedef struct packed {
    logic       spare_bit_d;
    logic       spare_bit_c;
    logic       spare_bit_b;
    logic       spare_bit_a;
    logic [3:0] preset_hi;
  } rtcx_phi_t;

endpackage : rtcx_pkg

// >>> design/rtcx_timer_ext.sv
// Countdown timer, update events and extension control behind a serial port
`timescale 1ns/10ps

module rtcx_timer_ext import rtcx_pkg::*; #(
  parameter int unsigned BASE_DIV_P = BASE_DIV,
  parameter int unsigned RTN_SEC_P  = RTN_SEC_CYC,
  parameter int unsigned RTN_MIN_P  = RTN_MIN_CYC,
  parameter logic [6:0]  DEV_ADDR   = DEV_ADDR_DEF
) (
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic       en_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       update_hold_i,
  output logic            alarm_source_select_o,
  output logic [1:0]      out_clock_freq_select_o,
  output logic            countdown_event_o,
  output logic            update_event_o,
  output logic            update_level_o,
  output logic [11:0]     countdown_value_o
);

  // Elaboration checks
  if (BASE_DIV_P < 2) begin : g_chk_div
    $error("BASE_DIV_P must be at least 2");
  end
  if (RTN_SEC_P < 1 || RTN_MIN_P < 1 ||
      RTN_SEC_P >= 2**27 || RTN_MIN_P >= 2**27) begin : g_chk_rtn
    $error("auto-return counts out of range");
  end

  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_ADDR = 9'h002,
    S_AACK = 9'h004,
    S_PTR  = 9'h008,
    S_PACK = 9'h010,
    S_WDAT = 9'h020,
    S_WACK = 9'h040,
    S_RDAT = 9'h080,
    S_RACK = 9'h100
  } rtcx_state_t;

  rtcx_state_t state;
  logic [2:0]  scl_sy;
  logic [2:0]  sda_sy;
  logic        scl_f;
  logic        sda_f;
  logic        scl_d;
  logic        sda_d;
  logic [3:0]  bitcnt;
  logic [7:0]  shreg;
  logic [7:0]  txreg;
  logic [4:0]  ptr;
  logic        rw_bit;
  logic        wr_stb;
  logic [3:0]  wr_idx;
  logic [7:0]  wr_dat;
  logic [7:0]  preset_lo;
  rtcx_phi_t   preset_hi;
  rtcx_ext_t   ext;

  // Pins outside the clock domain: change counts when stages 2 and 3 agree
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_sy <= 3'h7;
      sda_sy <= 3'h7;
      scl_f  <= 1'b1;
      sda_f  <= 1'b1;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
    end else if (en_i) begin
      scl_sy <= {scl_sy[1:0], scl_i};
      sda_sy <= {sda_sy[1:0], sda_i};
      if (scl_sy[1] == scl_sy[2]) scl_f <= scl_sy[2];
      if (sda_sy[1] == sda_sy[2]) sda_f <= sda_sy[2];
      scl_d  <= scl_f;
      sda_d  <= sda_f;
    end
  end

  // Bus conditions from filtered levels
  wire         scl_rise  = scl_f & ~scl_d;
  wire         scl_fall  = ~scl_f & scl_d;
  wire         bus_start = scl_f & scl_d & sda_d & ~sda_f;
  wire         bus_stop  = scl_f & scl_d & ~sda_d & sda_f;
  wire         byte_done = (bitcnt == 4'h8);
  wire         addr_hit  = (shreg[7:1] == DEV_ADDR);

  // Read mux; low nibble only, so both ranges alias
  wire [3:0]   rd_idx    = ptr[3:0];
  wire [7:0]   rd_data   =
                           (rd_idx == IDX_PRESET_LO) ? preset_lo :
                           (rd_idx == IDX_PRESET_HI) ? preset_hi :
                           (rd_idx == IDX_EXT_CTRL)  ? ext :
                           UNMAPPED_BYTE;

  assign sda_o = 1'b0; // Open drain: only ever pulls low

  // Serial target: address, pointer, then data bytes with auto-increment
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state    <= S_IDLE;
      bitcnt   <= 4'h0;
      shreg    <= RESET_BYTE;
      txreg    <= RESET_BYTE;
      ptr      <= 5'h00;
      rw_bit   <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_stb   <= 1'b0;
      wr_idx   <= 4'h0;
      wr_dat   <= RESET_BYTE;
    end else if (en_i) begin
      wr_stb <= 1'b0;
      if (bus_stop) begin
        state    <= S_IDLE;
        sda_oe_o <= 1'b0;
      end else if (bus_start) begin
        state    <= S_ADDR;
        bitcnt   <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (scl_rise) begin
        if (state == S_ADDR || state == S_PTR || state == S_WDAT) begin
          shreg  <= {shreg[6:0], sda_f};
          bitcnt <= bitcnt + 4'h1;
        end else if (state == S_RACK && sda_f) begin
          state <= S_IDLE; // Host said no more bytes
        end
      end else if (scl_fall) begin
        case (state)
          S_ADDR: if (byte_done) begin
            state    <= addr_hit ? S_AACK : S_IDLE;
            sda_oe_o <= addr_hit;
            rw_bit   <= shreg[0];
          end
          S_AACK: begin
            bitcnt <= 4'h0;
            if (rw_bit) begin
              state    <= S_RDAT;
              txreg    <= rd_data;
              sda_oe_o <= ~rd_data[7];
            end else begin
              state    <= S_PTR;
              sda_oe_o <= 1'b0;
            end
          end
          S_PTR: if (byte_done) begin
            state    <= S_PACK;
            sda_oe_o <= 1'b1;
          end
          S_PACK: begin
            ptr      <= shreg[4:0];
            state    <= S_WDAT;
            bitcnt   <= 4'h0;
            sda_oe_o <= 1'b0;
          end
          S_WDAT: if (byte_done) begin
            state    <= S_WACK;
            sda_oe_o <= 1'b1;
            wr_stb   <= 1'b1;
            wr_idx   <= ptr[3:0];
            wr_dat   <= shreg;
            ptr      <= ptr + 5'h01;
          end
          S_WACK: begin
            state    <= S_WDAT;
            bitcnt   <= 4'h0;
            sda_oe_o <= 1'b0;
          end
          S_RDAT: if (bitcnt == 4'h7) begin
            state    <= S_RACK;
            sda_oe_o <= 1'b0;
            ptr      <= ptr + 5'h01;
          end else begin
            bitcnt   <= bitcnt + 4'h1;
            txreg    <= {txreg[6:0], 1'b0};
            sda_oe_o <= ~txreg[6];
          end
          S_RACK: begin
            state    <= S_RDAT;
            bitcnt   <= 4'h0;
            txreg    <= rd_data;
            sda_oe_o <= ~rd_data[7];
          end
          default: begin
            state    <= S_IDLE;
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // Register storage; one copy serves both address ranges
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      preset_lo <= RESET_BYTE;
      preset_hi <= RESET_BYTE;
      ext       <= RESET_BYTE;
    end else if (en_i && wr_stb) begin
      if (wr_idx == IDX_PRESET_LO) preset_lo <= wr_dat;
      if (wr_idx == IDX_PRESET_HI) preset_hi <= wr_dat;
      if (wr_idx == IDX_EXT_CTRL)  ext       <= wr_dat;
    end
  end

  // Decoded controls
  wire [11:0]  preset    = {preset_hi.preset_hi, preset_lo};
  assign alarm_source_select_o   = ext.alarm_source_select;
  assign out_clock_freq_select_o = ext.out_clock_freq_select;

  // Timebase: 4096 Hz base tick, sub-ticks and seconds within a minute
  logic [$clog2(BASE_DIV_P)-1:0] pre_cnt;
  logic [11:0] base_cnt;
  logic [5:0]  sec_cnt;
  wire         base_tick = (pre_cnt == ($bits(pre_cnt))'(BASE_DIV_P - 1));
  wire         tick_64   = base_tick & (base_cnt[5:0] == TICKS_64HZ_M1);
  wire         tick_sec  = base_tick & (base_cnt == TICKS_1HZ_M1);
  wire         tick_min  = tick_sec & (sec_cnt == SECS_MIN_M1);

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pre_cnt  <= '0;
      base_cnt <= 12'h000;
      sec_cnt  <= 6'h00;
    end else if (en_i) begin
      pre_cnt <= base_tick ? '0 : pre_cnt + 1'b1;
      if (base_tick) base_cnt <= base_cnt + 12'h001;
      if (tick_sec)  sec_cnt  <= tick_min ? 6'h00 : sec_cnt + 6'h01;
    end
  end

  // Countdown source select
  wire         src_tick = (ext.countdown_source_select == SRC_4096HZ) ?
                          base_tick :
                          (ext.countdown_source_select == SRC_64HZ) ?
                          tick_64 :
                          (ext.countdown_source_select == SRC_1HZ) ?
                          tick_sec : tick_min;

  // Countdown: reload from preset each period; idle holds the preset
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      countdown_value_o <= 12'h000;
      countdown_event_o <= 1'b0;
    end else if (en_i) begin
      countdown_event_o <= 1'b0;
      if (!ext.countdown_run) begin
        countdown_value_o <= preset;
      end else if (src_tick && preset != 12'h000) begin
        if (countdown_value_o <= 12'h001) begin
          countdown_value_o <= preset;
          countdown_event_o <= 1'b1;
        end else begin
          countdown_value_o <= countdown_value_o - 12'h001;
        end
      end
    end
  end

  // Periodic update event with auto-return level
  localparam int unsigned RW = 27;
  logic [RW-1:0] rtn_cnt;
  wire         upd_tick = ext.update_period_select ? tick_min : tick_sec;
  wire [RW-1:0] rtn_load = ext.update_period_select ?
                           RW'(RTN_MIN_P) : RW'(RTN_SEC_P);

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rtn_cnt        <= '0;
      update_event_o <= 1'b0;
      update_level_o <= 1'b0;
    end else if (en_i) begin
      update_event_o <= 1'b0;
      if (update_hold_i) begin
        rtn_cnt        <= '0;
        update_level_o <= 1'b0;
      end else if (upd_tick) begin
        rtn_cnt        <= rtn_load;
        update_event_o <= 1'b1;
        update_level_o <= 1'b1;
      end else if (rtn_cnt != '0) begin
        rtn_cnt        <= rtn_cnt - 1'b1;
        update_level_o <= (rtn_cnt != RW'(1));
      end
    end
  end

endmodule : rtcx_timer_ext

// >>> dv/rtcx_timer_ext_sva.sv
// Checker: port-level timing properties of the timer block
`timescale 1ns/10ps
module rtcx_chk (
  input wire logic        clk_sys_i,
  input wire logic        nrst_i,
  input wire logic        scl_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o,
  input wire logic        update_hold_i,
  input wire logic        alarm_source_select_o,
  input wire logic        countdown_event_o,
  input wire logic        update_event_o,
  input wire logic        update_level_o,
  input wire logic [11:0] countdown_value_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // Bus: open drain only, answer steady while clock high
  a_sda_pull_only: assert property (sda_o == 1'h0)
    else $error("data pin driven high");
  a_oe_steady_high: assert property (
    scl_i [*6] |-> $stable(sda_oe_o))
    else $error("data answer moved while clock high");
  // Countdown pulses are spaced by at least four cycles
  a_cd_pulse_gap: assert property (
    countdown_event_o |=> !countdown_event_o [*3])
    else $error("countdown pulses too close");
  a_cd_reload_nz: assert property (
    countdown_event_o |-> countdown_value_o != 12'h000)
    else $error("countdown event with zero count");
  // Update level follows its event and lasts
  a_upd_level_on: assert property (
    update_event_o && !update_hold_i |=> update_level_o)
    else $error("update level missing");
  a_level_cause: assert property (
    $rose(update_level_o) |-> update_event_o || $past(update_event_o))
    else $error("update level without event");
  a_level_width: assert property (
    $rose(update_level_o) |-> (update_level_o || update_hold_i) [*8])
    else $error("update level too short");
  // Control reset halts updates
  a_hold_no_evt: assert property (
    update_hold_i [*2] |-> !update_event_o)
    else $error("update event while halted");
  a_hold_no_lvl: assert property (
    update_hold_i [*2] |-> !update_level_o)
    else $error("update level while halted");
  // Field changes only at a write acknowledge
  a_alarm_on_ack: assert property (
    $changed(alarm_source_select_o) |-> sda_oe_o)
    else $error("alarm source changed outside write");
  c_cd: cover property (countdown_event_o);
  c_upd: cover property (update_event_o);
  c_ack: cover property ($rose(sda_oe_o));
endmodule : rtcx_chk

bind rtcx_timer_ext rtcx_chk u_chk (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .update_hold_i(update_hold_i),
  .alarm_source_select_o(alarm_source_select_o),
  .countdown_event_o(countdown_event_o), .update_event_o(update_event_o),
  .update_level_o(update_level_o), .countdown_value_o(countdown_value_o));

// >>> dv/rtcx_host.sv
// Partner: two-wire bus host, pulls data low, pull-up elsewhere
`timescale 1ns/10ps
module rtcx_host import rtcx_pkg::*; (
  input  wire logic clk_sys_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  initial begin
    scl_o = 1'h1;
    sda_pull_o = 1'h0;
  end
  // One quarter slot, longer than the target's pin synchroniser
  task automatic drv(input logic c, input logic p);
    scl_o <= c;
    sda_pull_o <= p;
    repeat (6) @(posedge clk_sys_i);
  endtask : drv
  task automatic start();
    drv(scl_o, 1'h0);
    drv(1'h1, 1'h0);
    drv(1'h1, 1'h1);
    drv(1'h0, 1'h1);
  endtask : start
  task automatic stop();
    drv(1'h0, 1'h1);
    drv(1'h1, 1'h1);
    drv(1'h1, 1'h0);
  endtask : stop
  // Data set while low, sampled mid-high
  task automatic bit1(input logic b, output logic r);
    drv(1'h0, !b);
    drv(1'h1, !b);
    r = sda_i;
    drv(1'h1, !b);
    drv(1'h0, !b);
  endtask : bit1
  task automatic xfer(input logic [7:0] d, output logic [7:0] r,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit1(d[i], r[i]);
    end
    bit1(1'h1, ack);
  endtask : xfer
  task automatic wr(input logic [7:0] p, input logic [7:0] d,
                    output logic ok);
    logic [7:0] r;
    logic a0, a1, a2;
    start();
    xfer({DEV_ADDR_DEF, 1'h0}, r, a0);
    xfer(p, r, a1);
    xfer(d, r, a2);
    stop();
    ok = !(a0 | a1 | a2);
  endtask : wr
  // Reads end with a host NACK after one byte
  task automatic rd(input logic [7:0] p, output logic [7:0] d,
                    output logic ok);
    logic [7:0] r;
    logic a0, a1, a2, n;
    start();
    xfer({DEV_ADDR_DEF, 1'h0}, r, a0);
    xfer(p, r, a1);
    start();
    xfer({DEV_ADDR_DEF, 1'h1}, r, a2);
    xfer(8'hFF, d, n);
    stop();
    ok = !(a0 | a1 | a2);
  endtask : rd
endmodule : rtcx_host

// >>> dv/rtcx_timer_ext_test.sv
// Testbench: register access, countdown and update events
`timescale 1ns/10ps
module rtcx_timer_ext_test import rtcx_pkg::*;;
  localparam int BDIV = 4;
  localparam int RTN_S = 20;
  logic        clk_sys_i, nrst_i, en, hold, oe, pull, scl, evt, upd, lvl;
  logic        asrc;
  logic [1:0]  oclk;
  logic [11:0] val;
  wire         sda = !(oe | pull);
  int          failures, samples_checked;
  int          upd_seen = 0;
  rtcx_timer_ext #(.BASE_DIV_P(BDIV), .RTN_SEC_P(RTN_S), .RTN_MIN_P(10)) dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .en_i(en), .scl_i(scl),
    .sda_i(sda), .sda_o(), .sda_oe_o(oe), .update_hold_i(hold),
    .alarm_source_select_o(asrc), .out_clock_freq_select_o(oclk),
    .countdown_event_o(evt), .update_event_o(upd), .update_level_o(lvl),
    .countdown_value_o(val));
  rtcx_host host (.clk_sys_i(clk_sys_i), .sda_i(sda), .scl_o(scl),
    .sda_pull_o(pull));
  // Running count of update pulses, read by the minute-mode check
  always @(posedge clk_sys_i) begin
    if (upd === 1'h1) upd_seen <= upd_seen + 1;
  end
  task automatic chk(input logic c, input string m);
    samples_checked++;
    if (c !== 1'h1) begin
      failures++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic reg_wr(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    host.wr(p, d, ok);
    chk(ok, "write not acknowledged");
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] p, input logic [7:0] e);
    logic ok;
    logic [7:0] v;
    host.rd(p, v, ok);
    chk(ok === 1'h1 && v === e, "read value");
  endtask : reg_rd
  // Cycles until the next countdown pulse, bounded
  task automatic wait_evt(output int k);
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (evt !== 1'h1 && k < 40000);
  endtask : wait_evt
  task automatic t_regs();
    reg_rd(8'h0C, 8'h00);
    reg_rd(8'h0D, 8'h00);
    reg_wr(8'h1C, 8'hA5);
    reg_wr(8'h0B, 8'h03);
    reg_rd(8'h0C, 8'hA5);
    reg_rd(8'h1B, 8'h03);
    chk(val === 12'h503, "stopped count");
    reg_rd(8'h05, 8'h00);
    reg_wr(8'h1D, 8'h44);
    chk(asrc === 1'h1 && oclk === 2'h1, "ext fields");
    reg_rd(8'h0D, 8'h44);
    reg_wr(8'h0D, 8'h00);
    chk(asrc === 1'h0 && oclk === 2'h0, "ext fields clear");
  endtask : t_regs
  // Period per source code; 1/60 is too long to simulate. The 1 Hz pass
  // runs in minute-update mode, so no second update may show up there.
  task automatic t_count();
    logic [7:0]  lo [3] = '{8'h03, 8'h03, 8'h01};
    logic [7:0]  ctl [3] = '{8'h10, 8'h11, 8'h32};
    int          per [3] = '{3 * BDIV, 192 * BDIV, 4096 * BDIV};
    logic [11:0] v0;
    int          k, n, u0;
    reg_wr(8'h0C, 8'h00);
    for (int i = 0; i < 3; i++) begin
      reg_wr(8'h0B, lo[i]);
      reg_wr(8'h0D, ctl[i]);
      reg_rd(8'h0B, lo[i]);
      u0 = upd_seen;
      wait_evt(k);
      wait_evt(n);
      chk(n == per[i], "countdown period");
      if (i == 2) begin
        chk(upd_seen == u0, "second update in minute mode");
      end
      if (i == 0) begin
        // Clock enable low must freeze count and pulses
        en <= 1'h0;
        @(posedge clk_sys_i);
        v0 = val;
        n = 0;
        repeat (50) begin
          @(posedge clk_sys_i);
          n += (evt === 1'h1);
        end
        chk(n == 0 && val === v0, "frozen timer moved");
        en <= 1'h1;
      end
    end
    reg_wr(8'h1D, 8'h00);
    n = 0;
    repeat (200) begin
      @(posedge clk_sys_i);
      n += (evt === 1'h1);
    end
    chk(n == 0 && val === 12'h001, "stopped timer");
  endtask : t_count
  task automatic t_update();
    int k, n;
    k = 0;
    n = 0;
    while (upd !== 1'h1 && k < 20000) begin
      @(posedge clk_sys_i);
      k++;
    end
    while (lvl === 1'h1 && n < 100) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk(n >= RTN_S - 1 && n <= RTN_S + 1, "update width");
    hold <= 1'h1;
    repeat (3) @(posedge clk_sys_i);
    k = 0;
    repeat (17000) begin
      @(posedge clk_sys_i);
      k += (upd === 1'h1);
    end
    chk(k == 0 && lvl === 1'h0, "halted updates");
    hold <= 1'h0;
  endtask : t_update
  task automatic give_verdict();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    clk_sys_i = 1'h0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Watchdog: the run needs about 85000 cycles, so this leaves some margin
  initial begin
    repeat (99000) @(posedge clk_sys_i);
    failures++;
    $display("unexpected at %0t: watchdog", $time);
    give_verdict();
  end
  initial begin
    nrst_i = 1'h0;
    en = 1'h1;
    hold = 1'h0;
    failures = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk_sys_i);
    nrst_i <= 1'h1;
    repeat (5) @(posedge clk_sys_i);
    t_regs();
    t_count();
    t_update();
    give_verdict();
  end
endmodule : rtcx_timer_ext_test
